// ---- inc/icst_defines.vh ----
// Constants of the calibration status and timestamp block: register
// offsets, status bit positions, reset values and timing counts.
// Assumes inclusion by bare name from the rtl files.
//
// Function
// - Calibrating bit B10 while channel calibrates
// - B11 set on valid low reference
// - B12 set on invalid low reference
// - Abort with bad reference latches fault
// - B13 set on valid high reference
// - B14 set on invalid high reference
// - B15 set when calibration finishes cleanly
// - B15 held until connection closes
// - Channel value reported as real number
// - 64-bit sync timestamp of last sample
// - 16-bit millisecond counter wrapping at 32767
// - No output data; heartbeat kind checked
// - B9 set when last calibration failed
`ifndef ICST_DEFINES_VH
`define ICST_DEFINES_VH

// ---------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------
`define ICST_NCH          8
`define ICST_AW           8

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define ICST_STAT_BASE    8'h00
`define ICST_DATA_BASE    8'h20
`define ICST_TS_LO        8'h40
`define ICST_TS_HI        8'h44
`define ICST_ROLL_SNAP    8'h48
`define ICST_CTRL         8'h4C
`define ICST_IRQ_STAT     8'h50
`define ICST_IRQ_MASK     8'h54
`define ICST_ROLL_LIVE    8'h58

// ---------------------------------------------------------------
// Channel status bit positions
// ---------------------------------------------------------------
`define ICST_B_FAILED     9
`define ICST_B_CALIB      10
`define ICST_B_LOW_ACC    11
`define ICST_B_LOW_REJ    12
`define ICST_B_HIGH_ACC   13
`define ICST_B_HIGH_REJ   14
`define ICST_B_COMPLETE   15

// ---------------------------------------------------------------
// Control and interrupt fields
// ---------------------------------------------------------------
`define ICST_CTRL_MS_RUN  0
`define ICST_CTRL_RST     32'h0000_0001
`define ICST_EV_SAMPLE    0
`define ICST_EV_FAIL      1
`define ICST_EV_DONE      2
`define ICST_EV_HB_BAD    3
`define ICST_NEV          4
`define ICST_MASK_RST     4'h0

// ---------------------------------------------------------------
// Bus responses
// ---------------------------------------------------------------
`define ICST_RESP_OK      2'h0
`define ICST_RESP_ERR     2'h2

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define ICST_CLK_NS       10
`define ICST_MS_TIME_NS   1000000
`define ICST_MS_CYCLES    (`ICST_MS_TIME_NS / `ICST_CLK_NS)
`define ICST_ROLL_MAX     16'h7FFF

`endif

// ---- rtl/icst_cal_chan.v ----
// Calibration state and status flags of one input channel.
// Assumes one-cycle event pulses from the calibration sequencer.
`timescale 1ns/1ps
`include "icst_defines.vh"

module icst_cal_chan (
  input  wire clk,
  input  wire rst_n,
  input  wire conn_open,
  input  wire cal_start,
  input  wire low_smp,
  input  wire low_ok,
  input  wire high_smp,
  input  wire high_ok,
  input  wire cal_finish,
  input  wire cal_abort,
  output wire [6:0] flags,
  output reg  fail_evt,
  output reg  done_evt
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CAL  = 1'b1;

  reg state_q;
  reg low_acc_q;
  reg low_rej_q;
  reg high_acc_q;
  reg high_rej_q;
  reg complete_q;
  reg failed_q;
  wire ok_all;

  // Success needs both references accepted and none rejected
  assign ok_all = low_acc_q & high_acc_q & ~low_rej_q & ~high_rej_q;

  // ---------------------------------------------------------------
  // Calibration sequence
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    fail_evt <= 1'b0;
    done_evt <= 1'b0;
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      low_acc_q  <= 1'b0;
      low_rej_q  <= 1'b0;
      high_acc_q <= 1'b0;
      high_rej_q <= 1'b0;
      complete_q <= 1'b0;
      failed_q   <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cal_start) begin
            state_q    <= ST_CAL;
            low_acc_q  <= 1'b0;
            low_rej_q  <= 1'b0;
            high_acc_q <= 1'b0;
            high_rej_q <= 1'b0;
            complete_q <= 1'b0;
          end else if (!conn_open) begin
            complete_q <= 1'b0;
          end
        end
        ST_CAL: begin
          if (low_smp) begin
            low_acc_q <= low_ok;
            low_rej_q <= ~low_ok;
          end
          if (high_smp) begin
            high_acc_q <= high_ok;
            high_rej_q <= ~high_ok;
          end
          if (cal_abort) begin
            state_q  <= ST_IDLE;
            failed_q <= 1'b1;
            fail_evt <= 1'b1;
          end else if (cal_finish) begin
            state_q <= ST_IDLE;
            if (ok_all) begin
              complete_q <= conn_open;
              failed_q   <= 1'b0;
              done_evt   <= 1'b1;
            end else begin
              failed_q <= 1'b1;
              fail_evt <= 1'b1;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Flags in order B9..B15
  assign flags = {complete_q, high_rej_q, high_acc_q, low_rej_q,
                  low_acc_q, state_q, failed_q};

endmodule

// ---- rtl/icst_ms_counter.v ----
// Millisecond counter, counting while run is set, that wraps after 32767.
// Assumes a clock whose period divides one millisecond.
`timescale 1ns/1ps
`include "icst_defines.vh"

module icst_ms_counter #(
  parameter integer MS_CYCLES = `ICST_MS_CYCLES
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        run,
  output reg  [15:0] count
);

  reg [31:0] pre_q;

  // ---------------------------------------------------------------
  // Prescaler and count
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      pre_q <= 32'h0000_0000;
      count <= 16'h0000;
    end else if (run) begin
      if (pre_q == MS_CYCLES - 1) begin
        pre_q <= 32'h0000_0000;
        if (count == `ICST_ROLL_MAX)
          count <= 16'h0000;
        else
          count <= count + 16'h0001;
      end else begin
        pre_q <= pre_q + 32'h0000_0001;
      end
    end
  end

endmodule

// ---- rtl/icst_top.v ----
// Per-channel calibration status, channel values and timestamps,
// reached by software over an AXI4-Lite slave.
// Assumes all inputs synchronous to MCLK; event inputs are pulses.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "icst_defines.vh"

module icst_top #(
  parameter integer MS_CYCLES = `ICST_MS_CYCLES
) (
  input  wire        MCLK,
  input  wire        RSTN,
  // AXI4-Lite slave
  input  wire [7:0]  AWADDR,
  input  wire        AWVALID,
  output wire        AWREADY,
  input  wire [31:0] WDATA,
  input  wire [3:0]  WSTRB,
  input  wire        WVALID,
  output wire        WREADY,
  output wire [1:0]  BRESP,
  output wire        BVALID,
  input  wire        BREADY,
  input  wire [7:0]  ARADDR,
  input  wire        ARVALID,
  output wire        ARREADY,
  output wire [31:0] RDATA,
  output wire [1:0]  RRESP,
  output wire        RVALID,
  input  wire        RREADY,
  // Calibration sequencer events, one bit per channel
  input  wire [7:0]  CAL_START,
  input  wire [7:0]  CAL_LOW_SMP,
  input  wire [7:0]  CAL_LOW_OK,
  input  wire [7:0]  CAL_HIGH_SMP,
  input  wire [7:0]  CAL_HIGH_OK,
  input  wire [7:0]  CAL_FINISH,
  input  wire [7:0]  CAL_ABORT,
  // Channel values and sampling
  input  wire        CH_WR,
  input  wire [2:0]  CH_SEL,
  input  wire [31:0] CH_VALUE,
  input  wire        SAMPLE_DONE,
  input  wire [63:0] SYNC_TIME,
  // Connection
  input  wire        CONN_OPEN,
  input  wire        CONN_LISTEN,
  input  wire        HB_PULSE,
  input  wire        HB_KIND_LISTEN,
  output wire        IRQ
);

  // ---------------------------------------------------------------
  // Register select decoding
  // ---------------------------------------------------------------
  localparam [3:0] SEL_NONE = 4'h0;
  localparam [3:0] SEL_STAT = 4'h1;
  localparam [3:0] SEL_DATA = 4'h2;
  localparam [3:0] SEL_TSLO = 4'h3;
  localparam [3:0] SEL_TSHI = 4'h4;
  localparam [3:0] SEL_SNAP = 4'h5;
  localparam [3:0] SEL_CTRL = 4'h6;
  localparam [3:0] SEL_ISTA = 4'h7;
  localparam [3:0] SEL_IMSK = 4'h8;
  localparam [3:0] SEL_LIVE = 4'h9;

  // Maps a byte address to a register kind; unaligned is unmapped
  function [3:0] reg_sel;
    input [7:0] a;
    begin
      if (a[1:0] != 2'h0)
        reg_sel = SEL_NONE;
      else if ({a[7:5], 5'h00} == `ICST_STAT_BASE)
        reg_sel = SEL_STAT;
      else if ({a[7:5], 5'h00} == `ICST_DATA_BASE)
        reg_sel = SEL_DATA;
      else begin
        case (a)
          `ICST_TS_LO:     reg_sel = SEL_TSLO;
          `ICST_TS_HI:     reg_sel = SEL_TSHI;
          `ICST_ROLL_SNAP: reg_sel = SEL_SNAP;
          `ICST_CTRL:      reg_sel = SEL_CTRL;
          `ICST_IRQ_STAT:  reg_sel = SEL_ISTA;
          `ICST_IRQ_MASK:  reg_sel = SEL_IMSK;
          `ICST_ROLL_LIVE: reg_sel = SEL_LIVE;
          default:         reg_sel = SEL_NONE;
        endcase
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  reg         awready_q;
  reg         wready_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         aw_have_q;
  reg         w_have_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         arready_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;
  reg  [31:0] ctrl_q;
  reg  [3:0]  ista_q;
  reg  [3:0]  ista_d;
  reg  [3:0]  imsk_q;
  reg         irq_q;
  reg  [63:0] ts_q;
  reg  [15:0] snap_q;
  reg  [31:0] ch_data [0:7];
  reg  [31:0] rd_word;
  reg  [1:0]  rd_resp;
  wire        wr_go;
  wire [3:0]  wsel;
  wire [3:0]  rsel;
  wire [2:0]  rch;
  wire [15:0] ms_now;
  wire [7:0]  fail_evt;
  wire [7:0]  done_evt;
  wire [6:0]  ch_flags [0:7];
  wire [3:0]  ev_set;
  wire        hb_bad;

  // ---------------------------------------------------------------
  // Per-channel calibration status
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `ICST_NCH; gi = gi + 1) begin : g_ch
      icst_cal_chan u_chan (
        .clk        (MCLK),
        .rst_n      (RSTN),
        .conn_open  (CONN_OPEN),
        .cal_start  (CAL_START[gi]),
        .low_smp    (CAL_LOW_SMP[gi]),
        .low_ok     (CAL_LOW_OK[gi]),
        .high_smp   (CAL_HIGH_SMP[gi]),
        .high_ok    (CAL_HIGH_OK[gi]),
        .cal_finish (CAL_FINISH[gi]),
        .cal_abort  (CAL_ABORT[gi]),
        .flags      (ch_flags[gi]),
        .fail_evt   (fail_evt[gi]),
        .done_evt   (done_evt[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Millisecond counter
  // ---------------------------------------------------------------
  icst_ms_counter #(
    .MS_CYCLES (MS_CYCLES)
  ) u_ms (
    .clk   (MCLK),
    .rst_n (RSTN),
    .run   (ctrl_q[`ICST_CTRL_MS_RUN]),
    .count (ms_now)
  );

  // ---------------------------------------------------------------
  // Channel values, sample timestamp and millisecond snapshot
  // ---------------------------------------------------------------
  always @(posedge MCLK) begin
    if (CH_WR)
      ch_data[CH_SEL] <= CH_VALUE;
  end

  always @(posedge MCLK) begin
    if (!RSTN) begin
      ts_q   <= 64'h0000_0000_0000_0000;
      snap_q <= 16'h0000;
    end else if (SAMPLE_DONE) begin
      ts_q   <= SYNC_TIME;
      snap_q <= ms_now;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt events; set wins over write-one-to-clear
  // ---------------------------------------------------------------
  assign hb_bad = HB_PULSE & (HB_KIND_LISTEN != CONN_LISTEN);
  assign ev_set = {hb_bad, |done_evt, |fail_evt, SAMPLE_DONE};

  always @* begin
    ista_d = ista_q;
    if (wr_go && wsel == SEL_ISTA && w_strb_q[0])
      ista_d = ista_q & ~w_data_q[3:0];
    ista_d = ista_d | ev_set;
  end

  always @(posedge MCLK) begin
    if (!RSTN) begin
      ista_q <= 4'h0;
      irq_q  <= 1'b0;
    end else begin
      ista_q <= ista_d;
      irq_q  <= |(ista_d & imsk_q);
    end
  end

  // ---------------------------------------------------------------
  // Write channel: address and data in either order
  // ---------------------------------------------------------------
  assign wsel  = reg_sel(aw_addr_q);
  assign wr_go = aw_have_q & w_have_q & ~bvalid_q;

  always @(posedge MCLK) begin
    if (!RSTN) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `ICST_RESP_OK;
    end else begin
      if (awready_q && AWVALID) begin
        aw_addr_q <= AWADDR;
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (wready_q && WVALID) begin
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        // Only control and interrupt registers take writes
        if (wsel == SEL_CTRL || wsel == SEL_ISTA || wsel == SEL_IMSK)
          bresp_q <= `ICST_RESP_OK;
        else
          bresp_q <= `ICST_RESP_ERR;
      end
      if (bvalid_q && BREADY) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Control and mask registers, byte lane 0 only
  always @(posedge MCLK) begin
    if (!RSTN) begin
      ctrl_q <= `ICST_CTRL_RST;
      imsk_q <= `ICST_MASK_RST;
    end else if (wr_go && w_strb_q[0]) begin
      if (wsel == SEL_CTRL)
        ctrl_q <= {31'h0000_0000, w_data_q[`ICST_CTRL_MS_RUN]};
      if (wsel == SEL_IMSK)
        imsk_q <= w_data_q[3:0];
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  assign rsel = reg_sel(ARADDR);
  assign rch  = ARADDR[4:2];

  always @* begin
    rd_word = 32'h0000_0000;
    rd_resp = `ICST_RESP_OK;
    case (rsel)
      SEL_STAT: rd_word = {16'h0000, ch_flags[rch], 9'h000};
      SEL_DATA: rd_word = ch_data[rch];
      SEL_TSLO: rd_word = ts_q[31:0];
      SEL_TSHI: rd_word = ts_q[63:32];
      SEL_SNAP: rd_word = {16'h0000, snap_q};
      SEL_CTRL: rd_word = ctrl_q;
      SEL_ISTA: rd_word = {28'h0000000, ista_q};
      SEL_IMSK: rd_word = {28'h0000000, imsk_q};
      SEL_LIVE: rd_word = {16'h0000, ms_now};
      default:  rd_resp = `ICST_RESP_ERR;
    endcase
  end

  always @(posedge MCLK) begin
    if (!RSTN) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `ICST_RESP_OK;
    end else begin
      if (arready_q && ARVALID) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_word;
        rresp_q   <= rd_resp;
      end
      if (rvalid_q && RREADY) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign AWREADY = awready_q;
  assign WREADY  = wready_q;
  assign BVALID  = bvalid_q;
  assign BRESP   = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID  = rvalid_q;
  assign RDATA   = rdata_q;
  assign RRESP   = rresp_q;
  assign IRQ     = irq_q;

endmodule

// ---- verification/icst_field_model.sv ----
// Field side of the block: calibration sequencer, scaler, sampler and
// connection owner. Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ps

module icst_field_model (
  input  wire        clk,
  output reg  [55:0] ev,
  output reg         ch_wr,
  output reg  [2:0]  ch_sel,
  output reg  [31:0] ch_value,
  output reg         smp,
  output reg  [63:0] sync_time,
  output reg         conn_open,
  output reg         conn_listen,
  output reg         hb,
  output reg         hb_listen
);
  // Quiet state: owning connection open, no events under way
  initial begin
    ev = 56'h0;
    ch_wr = 1'b0;
    ch_sel = 3'h0;
    ch_value = 32'h0;
    smp = 1'b0;
    sync_time = 64'h0;
    conn_open = 1'b1;
    conn_listen = 1'b0;
    hb = 1'b0;
    hb_listen = 1'b0;
  end

  // One event pulse; field k of ev, quality level in field k+1 when k is 1 or 3
  task evt(input integer k, input [2:0] ch, input ok);
    @(posedge clk);
    ev[8*k +: 8] <= 8'h01 << ch;
    if (k == 1 || k == 3) ev[8*k+8 +: 8] <= {8{ok}};
    @(posedge clk);
    ev[8*k +: 8] <= 8'h00;
    if (k == 1 || k == 3) ev[8*k+8 +: 8] <= {8{!ok}};
  endtask

  // New scaled value of one channel; bus shows garbage afterwards
  task chval(input [2:0] ch, input [31:0] v);
    @(posedge clk);
    ch_wr <= 1'b1;
    ch_sel <= ch;
    ch_value <= v;
    @(posedge clk);
    ch_wr <= 1'b0;
    ch_sel <= ~ch;
    ch_value <= ~v;
  endtask

  // End of a sampling round with its synchronized time
  task sample(input [63:0] t);
    @(posedge clk);
    smp <= 1'b1;
    sync_time <= t;
    @(posedge clk);
    smp <= 1'b0;
    sync_time <= ~t;
  endtask

  // Heartbeat of the kind that fits the connection unless told wrong
  task hb_send(input wrong);
    @(posedge clk);
    hb <= 1'b1;
    hb_listen <= conn_listen ^ wrong;
    @(posedge clk);
    hb <= 1'b0;
  endtask
endmodule

// ---- verification/icst_tb_top.sv ----
// Self-checking bench of icst_top: AXI4-Lite tasks and test sequences.
// Assumes the checker is bound and the field model drives the events.
`timescale 1ns/1ps
`include "icst_defines.vh"

module icst_tb_top;
  localparam integer MS  = 2;
  localparam [1:0]   OK  = `ICST_RESP_OK;
  localparam [1:0]   ERR = `ICST_RESP_ERR;
  reg         MCLK    = 1'b0;
  reg         RSTN    = 1'b0;
  reg  [7:0]  AWADDR  = 8'h00;
  reg  [7:0]  ARADDR  = 8'h00;
  reg  [31:0] WDATA   = 32'h0;
  reg  [3:0]  WSTRB   = 4'h0;
  reg         AWVALID = 1'b0;
  reg         WVALID  = 1'b0;
  reg         BREADY  = 1'b0;
  reg         ARVALID = 1'b0;
  reg         RREADY  = 1'b0;
  wire        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  wire [1:0]  BRESP, RRESP;
  wire [31:0] RDATA, ch_value;
  wire [55:0] ev;
  wire [63:0] sync_time;
  wire [2:0]  ch_sel;
  wire        ch_wr, smp, conn_open, conn_listen, hb, hb_listen;
  integer     n_fail          = 0;
  integer     samples_checked = 0;

  icst_top #(.MS_CYCLES(MS)) uut (
    .MCLK(MCLK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .CAL_START(ev[7:0]), .CAL_LOW_SMP(ev[15:8]), .CAL_LOW_OK(ev[23:16]),
    .CAL_HIGH_SMP(ev[31:24]), .CAL_HIGH_OK(ev[39:32]),
    .CAL_FINISH(ev[47:40]), .CAL_ABORT(ev[55:48]), .CH_WR(ch_wr),
    .CH_SEL(ch_sel), .CH_VALUE(ch_value), .SAMPLE_DONE(smp),
    .SYNC_TIME(sync_time), .CONN_OPEN(conn_open), .CONN_LISTEN(conn_listen),
    .HB_PULSE(hb), .HB_KIND_LISTEN(hb_listen), .IRQ(IRQ));

  icst_field_model pm (
    .clk(MCLK), .ev(ev), .ch_wr(ch_wr), .ch_sel(ch_sel),
    .ch_value(ch_value), .smp(smp), .sync_time(sync_time),
    .conn_open(conn_open), .conn_listen(conn_listen), .hb(hb),
    .hb_listen(hb_listen));

  // Clock of 10 ns
  always #5 MCLK = ~MCLK;

  // Compare one result, count it, report a mismatch
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg aw_ok;
    reg w_ok;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge MCLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
      aw_ok = aw_ok | (AWVALID & AWREADY);
      w_ok = w_ok | (WVALID & WREADY);
    end
    do @(posedge MCLK); while (BVALID !== 1'b1);
    BREADY <= 1'b0;
    chk({30'h0, BRESP}, {30'h0, er});
  endtask

  // Read one word and compare data and response
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge MCLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge MCLK); while (RVALID !== 1'b1);
    RREADY <= 1'b0;
    chk(RDATA, ed);
    chk({30'h0, RRESP}, {30'h0, er});
  endtask

  task test_end(input string nm);
    $display("Test %0s finished at %0t", nm, $time);
  endtask

  // Counts, verdict and end of run
  task stop_test;
    $display("Checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    stop_test;
  end

  // Test sequence
  initial begin
    repeat (20) @(posedge MCLK);
    RSTN <= 1'b1;
    rd(`ICST_CTRL, `ICST_CTRL_RST, OK);
    rd(`ICST_IRQ_MASK, 32'h0, OK);
    rd(8'h0C, 32'h0, OK);
    rd(8'h5C, 32'h0, ERR);
    rd(8'h42, 32'h0, ERR);
    wr(`ICST_DATA_BASE, 32'h1, 4'hF, ERR);
    wr(`ICST_TS_LO, 32'h1, 4'hF, ERR);
    wr(`ICST_IRQ_MASK, 32'hF, 4'h0, OK);
    rd(`ICST_IRQ_MASK, 32'h0, OK);
    wr(`ICST_CTRL, 32'h0, 4'hF, OK);
    rd(`ICST_CTRL, 32'h0, OK);
    wr(`ICST_CTRL, 32'h1, 4'hF, OK);
    test_end("reset_and_access");
    pm.evt(0, 3'd3, 1'b0);
    rd(8'h0C, 32'h0000_0400, OK);
    pm.evt(1, 3'd3, 1'b1);
    pm.evt(3, 3'd3, 1'b0);
    rd(8'h0C, 32'h0000_4C00, OK);
    pm.evt(3, 3'd3, 1'b1);
    rd(8'h0C, 32'h0000_2C00, OK);
    pm.evt(5, 3'd3, 1'b0);
    rd(8'h0C, 32'h0000_A800, OK);
    rd(`ICST_IRQ_STAT, 32'h4, OK);
    test_end("cal_good");
    pm.evt(0, 3'd5, 1'b0);
    pm.evt(1, 3'd5, 1'b0);
    rd(8'h14, 32'h0000_1400, OK);
    pm.evt(6, 3'd5, 1'b0);
    rd(8'h14, 32'h0000_1200, OK);
    pm.evt(0, 3'd5, 1'b0);
    rd(8'h14, 32'h0000_0600, OK);
    pm.evt(1, 3'd5, 1'b1);
    pm.evt(3, 3'd5, 1'b0);
    pm.evt(5, 3'd5, 1'b0);
    rd(8'h14, 32'h0000_4A00, OK);
    pm.evt(0, 3'd5, 1'b0);
    pm.evt(1, 3'd5, 1'b1);
    pm.evt(3, 3'd5, 1'b1);
    pm.evt(5, 3'd5, 1'b0);
    rd(8'h14, 32'h0000_A800, OK);
    rd(`ICST_IRQ_STAT, 32'h6, OK);
    wr(`ICST_IRQ_STAT, 32'h6, 4'hF, OK);
    rd(`ICST_IRQ_STAT, 32'h0, OK);
    pm.conn_open <= 1'b0;
    repeat (2) @(posedge MCLK);
    rd(8'h0C, 32'h0000_2800, OK);
    pm.conn_open <= 1'b1;
    test_end("cal_fault_and_close");
    pm.chval(3'd2, 32'hC2C8_0000);
    rd(`ICST_DATA_BASE + 8'h08, 32'hC2C8_0000, OK);
    wr(`ICST_IRQ_MASK, 32'hF, 4'hF, OK);
    pm.sample(64'h0123_4567_89AB_CDEF);
    rd(`ICST_TS_LO, 32'h89AB_CDEF, OK);
    rd(`ICST_TS_HI, 32'h0123_4567, OK);
    chk({31'h0, IRQ}, 32'h1);
    pm.hb_send(1'b0);
    pm.hb_send(1'b1);
    rd(`ICST_IRQ_STAT, 32'h9, OK);
    wr(`ICST_IRQ_MASK, 32'h0, 4'hF, OK);
    @(posedge MCLK);
    chk({31'h0, IRQ}, 32'h0);
    wr(`ICST_IRQ_STAT, 32'h9, 4'hF, OK);
    rd(`ICST_IRQ_STAT, 32'h0, OK);
    test_end("values_and_interrupts");
    RSTN <= 1'b0;
    repeat (2) @(posedge MCLK);
    RSTN <= 1'b1;
    repeat (65546) @(posedge MCLK);
    pm.sample(64'h0);
    rd(`ICST_ROLL_SNAP, 32'h5, OK);
    rd(`ICST_ROLL_LIVE, 32'h8, OK);
    test_end("ms_wrap");
    stop_test;
  end
endmodule

// ---- verification/icst_top_sva.sv ----
// Checker of icst_top: bus handshakes and status words as they are read.
// Assumes it is bound to icst_top and sees only that module's ports.
`timescale 1ns/1ps
`include "icst_defines.vh"

module icst_top_sva (
  input wire        MCLK,
  input wire        RSTN,
  input wire [7:0]  ARADDR,
  input wire        ARVALID,
  input wire        ARREADY,
  input wire [31:0] RDATA,
  input wire [1:0]  RRESP,
  input wire        RVALID,
  input wire        RREADY,
  input wire        AWREADY,
  input wire        WREADY,
  input wire        BVALID,
  input wire        BREADY,
  input wire        IRQ
);
  reg  [7:0] rd_addr_q;
  wire       stat_rd;
  wire       roll_rd;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  // Address of the read under way, held while its answer stands
  always @(posedge MCLK) begin
    if (ARVALID && ARREADY) begin
      rd_addr_q <= ARADDR;
    end
  end

  // Accepted reads of a channel status word or of a millisecond count
  assign stat_rd = RVALID && RRESP == `ICST_RESP_OK
                   && rd_addr_q < `ICST_DATA_BASE;
  assign roll_rd = RVALID && RRESP == `ICST_RESP_OK
                   && (rd_addr_q == `ICST_ROLL_SNAP
                       || rd_addr_q == `ICST_ROLL_LIVE);

  a_read_latency: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer not one cycle after address");
  a_read_once: assert property (RVALID && RREADY |=> !RVALID && ARREADY)
    else $error("read answer outlived its handshake");
  a_read_blocked: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while an answer stands");
  a_write_blocked: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while a response stands");
  a_write_once: assert property (BVALID && BREADY |=> !BVALID ##0 AWREADY)
    else $error("write response outlived its handshake");
  a_err_data: assert property (RVALID && RRESP == `ICST_RESP_ERR
                               |-> RDATA == 32'h0)
    else $error("refused read returned data");
  a_low_exclusive: assert property (
    stat_rd |-> !(RDATA[11] && RDATA[12]))
    else $error("low reference both accepted and rejected");
  a_high_exclusive: assert property (
    stat_rd |-> !(RDATA[13] && RDATA[14]))
    else $error("high reference both accepted and rejected");
  a_done_clean: assert property (
    stat_rd && RDATA[15] |-> RDATA[14:9] == 6'b01_0100)
    else $error("complete flag beside busy, fault or bad reference");
  a_stat_unused: assert property (stat_rd |-> RDATA[8:0] == 9'h0
                                  && RDATA[31:16] == 16'h0)
    else $error("unused status bits set");
  a_roll_range: assert property (
    roll_rd |-> RDATA[31:15] == 17'h0)
    else $error("millisecond count beyond its wrap point");
  a_irq_release: assert property ($rose(RSTN) |-> !IRQ)
    else $error("interrupt high at reset release");
endmodule

bind icst_top icst_top_sva u_sva (
  .MCLK(MCLK), .RSTN(RSTN), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
  .RREADY(RREADY), .AWREADY(AWREADY), .WREADY(WREADY), .BVALID(BVALID),
  .BREADY(BREADY), .IRQ(IRQ));
